// ### cchf_pkg.sv
package cchf_pkg;
	// Register byte addresses
	localparam logic [7:0] REG_MODE     = 8'h00;
	localparam logic [7:0] REG_CMPVAL   = 8'h04;
	localparam logic [7:0] REG_HYST     = 8'h08;
	localparam logic [7:0] REG_LIMHI    = 8'h0c;
	localparam logic [7:0] REG_LIMLO    = 8'h10;
	localparam logic [7:0] REG_INTEG    = 8'h14;
	localparam logic [7:0] REG_IRQEN    = 8'h18;
	localparam logic [7:0] REG_IRQSTAT  = 8'h1c;
	localparam logic [7:0] REG_IRQMASK  = 8'h20;
	localparam logic [7:0] REG_COUNT    = 8'h24;
	localparam logic [7:0] REG_FREQ     = 8'h28;
	localparam logic [7:0] REG_STATUS   = 8'h2c;
	localparam logic [7:0] REG_LOAD     = 8'h30;
	// Mode register fields
	localparam int MODE_CNT_EN   = 0;
	localparam int MODE_FREQ     = 1;
	localparam int MODE_PULSE    = 2;
	localparam int MODE_DOWN     = 3;
	localparam int MODE_HWGATE   = 4;
	localparam int MODE_DIAGSEL  = 5;
	// Interrupt bits
	localparam int IRQ_CMP   = 0;
	localparam int IRQ_OVF   = 1;
	localparam int IRQ_UNF   = 2;
	localparam int IRQ_GOPEN = 3;
	localparam int IRQ_GCLS  = 4;
	localparam int IRQ_MEAS  = 5;
	localparam int IRQ_LOST  = 6;
	localparam int IRQ_W     = 7;
	// Reset values and integration time limits
	localparam logic [31:0] RST_LIMHI  = 32'h7fffffff;
	localparam logic [31:0] RST_LIMLO  = 32'h80000000;
	localparam logic [13:0] RST_INTEG  = 14'h0064;
	localparam logic [13:0] INTEG_MIN  = 14'h000a;
	localparam logic [13:0] INTEG_MAX  = 14'h2710;
	localparam logic [IRQ_W-1:0] RST_IRQEN = 7'h00;
	// Timing
	localparam int CLK_MHZ       = 250;
	localparam int MS_STEP_US    = 1000;
	localparam int CYC_PER_MS    = CLK_MHZ * MS_STEP_US;
endpackage : cchf_pkg

// ### cchf_counter.sv
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
//
// Contract
// RL1: Comparison hit arms hysteresis, holds result
// RL2: Re-arm only on next comparison hit
// RL3: Zero-pulse mode: equal sets output, arms
// RL4: Equal again while armed: no new event
// RL5: Clear only outside band and above
// RL6: Comparison hit interrupt, enableable
// RL7: Overflow interrupt, enableable
// RL8: Underflow interrupt, enableable
// RL9: Hardware gate open/close interrupts, not counter 3
// RL10: Count pulses per period, publish count
// RL11: Integration period 10 to 10000 ms
// RL12: Frequency input is counter B input
// RL13: User program calls control cyclically
// RL14: Band 0..255, 0 and 1 disable
// RL15: Hysteresis on all evaluations, late update
// RL16: End-of-measurement interrupt, off by default
// RL17: Diagnostic interrupt only on lost interrupt
// RL18: Pending flags; repeat while pending is lost
module cchf_counter #(
	parameter int          CHAN_ID    = 0,            // Channel number, 3 has no gate irq
	parameter int unsigned MS_CYCLES  = cchf_pkg::CYC_PER_MS // Clocks per millisecond
) (
	input  wire logic        clk_sys,    // System clock
	input  wire logic        sys_rst,    // Sync reset, active high
	input  wire logic        pinA,       // Count pulse input A
	input  wire logic        pinB,       // Input B, frequency source
	input  wire logic        pinGate,    // Hardware gate input
	input  wire logic [7:0]  regAddr,    // Register byte address
	input  wire logic [31:0] regWdata,   // Write data
	input  wire logic        regWr,      // Write strobe
	input  wire logic        regRd,      // Read strobe
	output logic      [31:0] regRdata,   // Read data, cycle after strobe
	output logic             cmpOut,     // Counter output channel
	output logic             irqOut,     // Process interrupt level
	output logic             diagIrq     // Diagnostic interrupt level
);

	// Synchronisers
	logic [1:0] syncA_q, syncB_q, syncG_q;
	logic       aLast_q, bLast_q, gLast_q;
	logic       aRise, bRise, gRise, gFall;

	// Configuration
	logic [5:0]          mode_q;
	logic signed [31:0]  cmpVal_q, limHi_q, limLo_q, load_q;
	logic [7:0]          hyst_q, hystAct_q;
	logic [13:0]         integ_q;
	logic [cchf_pkg::IRQ_W-1:0] irqEn_q, irqStat_q, irqMask_q;

	// State
	logic signed [31:0]  count_q;
	logic [31:0]         freq_q, pulseCnt_q;
	logic [31:0]         cycCnt_q;
	logic [13:0]         msCnt_q;
	logic                hystOn_q;
	logic signed [31:0]  hystCtr_q;
	logic                cmpRes_q;
	logic [cchf_pkg::IRQ_W-1:0] evt;
	logic                ovf, unf, cmpHit, gateOpen, measEnd;
	logic                statRdClr;

	// Band check against centre with active width
	function automatic logic outside_band(input logic signed [31:0] v,
		input logic signed [31:0] c, input logic [7:0] w);
		logic signed [32:0] d;
		logic signed [32:0] wd;
		d = 33'(v) - 33'(c);
		// Width kept signed so a negative distance is not read as huge
		wd = $signed({25'h0, w});
		outside_band = (d > wd) || (d < -wd);
	endfunction

	// Pin A synchroniser; history resets to the idle low level, no false edge
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			syncA_q <= 2'h0;
			aLast_q <= 1'b0;
		end else begin
			syncA_q <= {syncA_q[0], pinA};
			aLast_q <= syncA_q[1];
		end
	end

	// Pin B synchroniser; only the second stage feeds logic
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			syncB_q <= 2'h0;
			bLast_q <= 1'b0;
		end else begin
			syncB_q <= {syncB_q[0], pinB};
			bLast_q <= syncB_q[1];
		end
	end

	// Gate pin synchroniser
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			syncG_q <= 2'h0;
			gLast_q <= 1'b0;
		end else begin
			syncG_q <= {syncG_q[0], pinGate};
			gLast_q <= syncG_q[1];
		end
	end

	assign aRise = syncA_q[1] & ~aLast_q;
	assign bRise = syncB_q[1] & ~bLast_q;
	assign gRise = syncG_q[1] & ~gLast_q;
	assign gFall = ~syncG_q[1] & gLast_q;
	assign gateOpen = mode_q[cchf_pkg::MODE_CNT_EN];

	// Configuration writes
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode_q    <= 6'h00;
			cmpVal_q  <= 32'h00000000;
			hyst_q    <= 8'h00;
			limHi_q   <= cchf_pkg::RST_LIMHI;
			limLo_q   <= cchf_pkg::RST_LIMLO;
			load_q    <= 32'h00000000;
			irqEn_q   <= cchf_pkg::RST_IRQEN; // see RL16
			irqMask_q <= {cchf_pkg::IRQ_W{1'b1}};
		end else if (regWr) begin
			case (regAddr)
				cchf_pkg::REG_MODE:    mode_q <= regWdata[5:0];
				cchf_pkg::REG_CMPVAL:  cmpVal_q <= regWdata;
				cchf_pkg::REG_HYST:    hyst_q <= regWdata[7:0]; // see RL14
				cchf_pkg::REG_LIMHI:   limHi_q <= regWdata;
				cchf_pkg::REG_LIMLO:   limLo_q <= regWdata;
				cchf_pkg::REG_LOAD:    load_q <= regWdata;
				cchf_pkg::REG_IRQEN:   irqEn_q <= regWdata[cchf_pkg::IRQ_W-1:0];
				cchf_pkg::REG_IRQMASK: irqMask_q <= regWdata[cchf_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Integration time, clamped into the legal 1 ms grid range
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			integ_q <= cchf_pkg::RST_INTEG;
		end else if (regWr && regAddr == cchf_pkg::REG_INTEG) begin
			if (regWdata < 32'(cchf_pkg::INTEG_MIN))
				integ_q <= cchf_pkg::INTEG_MIN; // see RL11
			else if (regWdata > 32'(cchf_pkg::INTEG_MAX))
				integ_q <= cchf_pkg::INTEG_MAX; // see RL11
			else
				integ_q <= regWdata[13:0];
		end
	end

	// Up/down counter with limits; overflow reloads
	// A load write wins over a count edge in the same cycle, so software
	// always sees its own value first. Limits are inclusive end points.
	// Counting stops while the software gate is closed.
	assign ovf = aRise && !mode_q[cchf_pkg::MODE_FREQ] && gateOpen
		&& !mode_q[cchf_pkg::MODE_DOWN] && (count_q >= limHi_q);
	assign unf = aRise && !mode_q[cchf_pkg::MODE_FREQ] && gateOpen
		&& mode_q[cchf_pkg::MODE_DOWN] && (count_q <= limLo_q);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			count_q <= 32'sh00000000;
		end else if (regWr && regAddr == cchf_pkg::REG_LOAD) begin
			count_q <= regWdata;
		end else if (aRise && gateOpen && !mode_q[cchf_pkg::MODE_FREQ]) begin
			if (ovf || unf)
				count_q <= load_q; // see RL7
			else if (mode_q[cchf_pkg::MODE_DOWN])
				count_q <= count_q - 32'sh1;
			else
				count_q <= count_q + 32'sh1;
		end
	end

	// Comparator with hysteresis, latched band width at arm time
	// The band is centred on the count at the arming hit. A width written
	// while armed waits for the next arming, so a running band never jumps.
	// In pulse mode only an exact hit arms, and leaving the band below the
	// compare value keeps the output set.
	assign cmpHit = mode_q[cchf_pkg::MODE_PULSE] ? (count_q == cmpVal_q)
		: (count_q >= cmpVal_q);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hystOn_q  <= 1'b0;
			hystAct_q <= 8'h00;
			hystCtr_q <= 32'sh0;
			cmpRes_q  <= 1'b0;
		end else if (!hystOn_q) begin
			if (cmpHit && !cmpRes_q) begin
				cmpRes_q <= 1'b1; // see RL3
				// Width 0 and 1 never arm
				hystOn_q  <= (hyst_q > 8'h01); // see RL1, RL14
				hystAct_q <= hyst_q; // see RL15
				hystCtr_q <= count_q;
			end else if (!cmpHit) begin
				if (!mode_q[cchf_pkg::MODE_PULSE] || count_q > cmpVal_q)
					cmpRes_q <= 1'b0; // see RL5
			end
		end else if (outside_band(count_q, hystCtr_q, hystAct_q)) begin
			hystOn_q <= 1'b0; // see RL2
			if (mode_q[cchf_pkg::MODE_PULSE])
				cmpRes_q <= (count_q > cmpVal_q) ? 1'b0 : cmpRes_q; // see RL5
			else
				cmpRes_q <= cmpHit;
		end
		// Inside band the result is frozen; repeated hits start nothing, see RL4
	end

	// Frequency measurement timebase and pulse accumulation on input B
	assign measEnd = mode_q[cchf_pkg::MODE_FREQ] && gateOpen
		&& (cycCnt_q == MS_CYCLES - 1) && (msCnt_q >= integ_q - 14'h1);

	// Millisecond timebase, held clear while measurement is off
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !mode_q[cchf_pkg::MODE_FREQ] || !gateOpen) begin
			cycCnt_q <= 32'h0;
			msCnt_q  <= 14'h0;
		end else if (measEnd) begin
			cycCnt_q <= 32'h0;
			msCnt_q  <= 14'h0;
		end else if (cycCnt_q == MS_CYCLES - 1) begin
			cycCnt_q <= 32'h0;
			msCnt_q  <= msCnt_q + 14'h1; // see RL11
		end else begin
			cycCnt_q <= cycCnt_q + 32'h1;
		end
	end

	// Rising edges on B; an edge in the closing cycle belongs to that period only
	always_ff @(posedge clk_sys) begin
		if (sys_rst || !mode_q[cchf_pkg::MODE_FREQ] || !gateOpen)
			pulseCnt_q <= 32'h0;
		else if (measEnd)
			pulseCnt_q <= 32'h0; // see RL10
		else if (bRise)
			pulseCnt_q <= pulseCnt_q + 32'h1; // see RL12
	end

	// Published frequency value, closing edge included
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			freq_q <= 32'h0;
		else if (measEnd)
			freq_q <= pulseCnt_q + {31'h0, bRise}; // see RL10
	end

	// Events gathered, each enabled per configuration
	// Every event is a one-cycle strobe, so a pending bit marks exactly one
	// occurrence and a second strobe can be told apart as lost.
	always_comb begin
		evt = '0;
		evt[cchf_pkg::IRQ_CMP]   = cmpHit && !cmpRes_q && !hystOn_q; // see RL6
		evt[cchf_pkg::IRQ_OVF]   = ovf; // see RL7
		evt[cchf_pkg::IRQ_UNF]   = unf; // see RL8
		evt[cchf_pkg::IRQ_GOPEN] = (CHAN_ID != 3) && gateOpen
			&& mode_q[cchf_pkg::MODE_HWGATE] && gRise; // see RL9
		evt[cchf_pkg::IRQ_GCLS]  = (CHAN_ID != 3) && gateOpen
			&& mode_q[cchf_pkg::MODE_HWGATE] && gFall; // see RL9
		evt[cchf_pkg::IRQ_MEAS]  = measEnd; // see RL16
		evt = evt & irqEn_q;
	end

	// A read of the status word clears it
	assign statRdClr = regRd && (regAddr == cchf_pkg::REG_IRQSTAT);

	// Sticky status: set wins over read-clear; repeat while pending is lost
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irqStat_q <= '0;
		end else begin
			// Event bits: a new event in the clearing cycle survives
			if (statRdClr)
				irqStat_q[cchf_pkg::IRQ_W-2:0] <= evt[cchf_pkg::IRQ_W-2:0]; // see RL18
			else
				irqStat_q[cchf_pkg::IRQ_W-2:0] <= evt[cchf_pkg::IRQ_W-2:0]
					| irqStat_q[cchf_pkg::IRQ_W-2:0]; // see RL18
			// Lost flag: an enabled event that finds its bit still pending
			if (!mode_q[cchf_pkg::MODE_DIAGSEL])
				irqStat_q[cchf_pkg::IRQ_LOST] <= 1'b0;
			else if (|(evt[cchf_pkg::IRQ_W-2:0] & irqStat_q[cchf_pkg::IRQ_W-2:0]))
				irqStat_q[cchf_pkg::IRQ_LOST] <= 1'b1; // see RL17, RL18
			else if (statRdClr)
				irqStat_q[cchf_pkg::IRQ_LOST] <= 1'b0;
		end
	end

	// Comparison output, one stage behind the result
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			cmpOut <= 1'b0;
		else
			cmpOut <= cmpRes_q;
	end

	// Process interrupt level from the unmasked event bits
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			irqOut <= 1'b0;
		else
			irqOut <= |(irqStat_q[cchf_pkg::IRQ_W-2:0] & irqMask_q[cchf_pkg::IRQ_W-2:0]);
	end

	// Diagnostic level from the lost flag
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			diagIrq <= 1'b0;
		else
			diagIrq <= irqStat_q[cchf_pkg::IRQ_LOST] & irqMask_q[cchf_pkg::IRQ_LOST]; // see RL17
	end

	// Read port, data one cycle after strobe
	// Data returns to zero in every other cycle, so a stale word is never
	// mistaken for a fresh answer.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			regRdata <= 32'h0;
		end else if (regRd) begin
			case (regAddr)
				cchf_pkg::REG_MODE:    regRdata <= {26'h0, mode_q};
				cchf_pkg::REG_CMPVAL:  regRdata <= cmpVal_q;
				cchf_pkg::REG_HYST:    regRdata <= {24'h0, hyst_q};
				cchf_pkg::REG_LIMHI:   regRdata <= limHi_q;
				cchf_pkg::REG_LIMLO:   regRdata <= limLo_q;
				cchf_pkg::REG_LOAD:    regRdata <= load_q;
				cchf_pkg::REG_INTEG:   regRdata <= {18'h0, integ_q};
				cchf_pkg::REG_IRQEN:   regRdata <= {25'h0, irqEn_q};
				cchf_pkg::REG_IRQSTAT: regRdata <= {25'h0, irqStat_q};
				cchf_pkg::REG_IRQMASK: regRdata <= {25'h0, irqMask_q};
				cchf_pkg::REG_COUNT:   regRdata <= count_q;
				cchf_pkg::REG_FREQ:    regRdata <= freq_q;
				cchf_pkg::REG_STATUS:  regRdata <= {30'h0, hystOn_q, cmpRes_q};
				default:               regRdata <= 32'h0;
			endcase
		end else begin
			regRdata <= 32'h0;
		end
	end

endmodule // cchf_counter

// ### cchf_properties.sv
`timescale 1ns/10ps
module cchf_properties (
	input wire logic        clk_sys,  // System clock
	input wire logic        sys_rst,  // Sync reset
	input wire logic [7:0]  regAddr,  // Register address
	input wire logic        regRd,    // Read strobe
	input wire logic [31:0] regRdata, // Read data
	input wire logic        cmpOut,   // Compare output
	input wire logic        irqOut,   // Process interrupt
	input wire logic        diagIrq   // Diagnostic interrupt
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Read request of one register
	sequence rdAt(logic [7:0] a);
		regRd && regAddr == a;
	endsequence
	rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 32'h0) else $error("rdata not idle");
	unmapped_rd_a: assert property (regRd && (regAddr > 8'h30 || regAddr[1:0] != 2'h0)
		|=> regRdata == 32'h0) else $error("unmapped read not zero");
	integ_range_a: assert property (rdAt(cchf_pkg::REG_INTEG) |=> regRdata >= 32'h0000000a
		&& regRdata <= 32'h00002710) else $error("integration out of range");
	hyst_width_a: assert property (rdAt(cchf_pkg::REG_HYST) |=> regRdata[31:8] == 24'h0)
		else $error("hysteresis width wrong");
	irqen_width_a: assert property (rdAt(cchf_pkg::REG_IRQEN) |=> regRdata[31:7] == 25'h0)
		else $error("enable width wrong");
	stat_width_a: assert property (rdAt(cchf_pkg::REG_IRQSTAT) |=> regRdata[31:7] == 25'h0)
		else $error("status width wrong");
	mask_width_a: assert property (rdAt(cchf_pkg::REG_IRQMASK) |=> regRdata[31:7] == 25'h0)
		else $error("mask width wrong");
	reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !irqOut && !diagIrq && !cmpOut)
		else $error("outputs active after reset");
endmodule // cchf_properties

// ### cchf_field.sv
`timescale 1ns/10ps
module cchf_field (
	input wire logic clk_sys, // System clock
	output logic     pinA,    // Count pulses
	output logic     pinB,    // Frequency pulses
	output logic     pinGate  // Gate level, held closed
);
	initial begin
		pinA = 1'b0;
		pinB = 1'b0;
		pinGate = 1'b0;
	end
	// Pulses of three cycles high, three low, slow enough for the pin synchroniser
	task automatic pulse(input bit useB, input int n);
		repeat (n) begin
			@(posedge clk_sys);
			if (useB) pinB <= 1'b1; else pinA <= 1'b1;
			repeat (3) @(posedge clk_sys);
			if (useB) pinB <= 1'b0; else pinA <= 1'b0;
			repeat (2) @(posedge clk_sys);
		end
	endtask
endmodule // cchf_field

// ### cchf_counter_tb.sv
`timescale 1ns/10ps
module cchf_counter_tb;
	logic clk_sys = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
	logic pinA, pinB, pinGate, cmpOut, irqOut, diagIrq;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata;
	int err_count = 0, n_tests = 0;
	always #2 clk_sys = ~clk_sys;
	cchf_counter #(.CHAN_ID(0), .MS_CYCLES(10)) cchf_counter_inst (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .pinA(pinA), .pinB(pinB), .pinGate(pinGate), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.cmpOut(cmpOut), .irqOut(irqOut), .diagIrq(diagIrq));
	cchf_field cchf_field_inst (.clk_sys(clk_sys), .pinA(pinA), .pinB(pinB), .pinGate(pinGate));
	// Compare helpers
	task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask
	// Register bus cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWr <= 1'b1; regAddr <= a; regWdata <= d;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		@(posedge clk_sys);
		regRd <= 1'b1; regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 chk32(nm, e, regRdata);
	endtask
	task automatic waitIrq();
		int i;
		for (i = 0; i < 400 && irqOut !== 1'b1; i++) @(posedge clk_sys);
		#1 chk1("irq wait", 1'b1, irqOut);
	endtask
	task automatic conclude();
		$display("mismatches %0d of %0d comparisons", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		#80000;
		err_count++;
		conclude();
	end
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(cchf_pkg::REG_LIMHI, 32'h7fffffff, "limhi");
		rd(cchf_pkg::REG_LIMLO, 32'h80000000, "limlo");
		rd(cchf_pkg::REG_INTEG, 32'h00000064, "integ");
		rd(cchf_pkg::REG_IRQEN, 32'h00000000, "irqen");
		rd(8'hfc, 32'h0, "unmapped");
		wr(cchf_pkg::REG_INTEG, 32'h5);
		rd(cchf_pkg::REG_INTEG, 32'h0000000a, "integ low");
		wr(cchf_pkg::REG_INTEG, 32'h4e20);
		rd(cchf_pkg::REG_INTEG, 32'h00002710, "integ high");
		// Compare hit and overflow, first masked
		wr(cchf_pkg::REG_LOAD, 32'h0);
		wr(cchf_pkg::REG_CMPVAL, 32'h5);
		wr(cchf_pkg::REG_LIMHI, 32'h8);
		wr(cchf_pkg::REG_LIMLO, 32'hfffffffe);
		wr(cchf_pkg::REG_IRQEN, 32'h07);
		wr(cchf_pkg::REG_IRQMASK, 32'h0);
		wr(cchf_pkg::REG_MODE, 32'h1);
		cchf_field_inst.pulse(1'b0, 5);
		repeat (8) @(posedge clk_sys);
		rd(cchf_pkg::REG_COUNT, 32'h5, "count");
		chk1("cmp out", 1'b1, cmpOut);
		chk1("masked irq", 1'b0, irqOut);
		wr(cchf_pkg::REG_IRQMASK, 32'h7f);
		repeat (3) @(posedge clk_sys);
		#1 chk1("cmp irq", 1'b1, irqOut);
		rd(cchf_pkg::REG_IRQSTAT, 32'h01, "cmp stat");
		repeat (3) @(posedge clk_sys);
		#1 chk1("irq cleared", 1'b0, irqOut);
		cchf_field_inst.pulse(1'b0, 4);
		repeat (8) @(posedge clk_sys);
		rd(cchf_pkg::REG_COUNT, 32'h0, "wrapped");
		chk1("cmp out low", 1'b0, cmpOut);
		rd(cchf_pkg::REG_IRQSTAT, 32'h02, "ovf stat");
		// Underflow when counting down
		wr(cchf_pkg::REG_MODE, 32'h9);
		cchf_field_inst.pulse(1'b0, 3);
		repeat (8) @(posedge clk_sys);
		rd(cchf_pkg::REG_IRQSTAT, 32'h04, "unf stat");
		// Zero-duration pulse mode with a band of three around the hit
		wr(cchf_pkg::REG_LIMHI, 32'h7fffffff);
		wr(cchf_pkg::REG_HYST, 32'h3);
		wr(cchf_pkg::REG_MODE, 32'h5);
		cchf_field_inst.pulse(1'b0, 5);
		repeat (8) @(posedge clk_sys);
		rd(cchf_pkg::REG_STATUS, 32'h3, "armed");
		chk1("pulse out", 1'b1, cmpOut);
		cchf_field_inst.pulse(1'b0, 3);
		repeat (8) @(posedge clk_sys);
		rd(cchf_pkg::REG_STATUS, 32'h3, "in band");
		cchf_field_inst.pulse(1'b0, 1);
		repeat (8) @(posedge clk_sys);
		rd(cchf_pkg::REG_STATUS, 32'h0, "left band");
		chk1("pulse out off", 1'b0, cmpOut);
		// A hit while its bit is still pending is lost
		wr(cchf_pkg::REG_LOAD, 32'h0);
		wr(cchf_pkg::REG_MODE, 32'h21);
		cchf_field_inst.pulse(1'b0, 5);
		repeat (8) @(posedge clk_sys);
		#1 chk1("diag irq", 1'b1, diagIrq);
		rd(cchf_pkg::REG_IRQSTAT, 32'h41, "lost stat");
		repeat (3) @(posedge clk_sys);
		#1 chk1("diag cleared", 1'b0, diagIrq);
		// Frequency over a 100 cycle period, B input only
		wr(cchf_pkg::REG_INTEG, 32'h0a);
		wr(cchf_pkg::REG_IRQEN, 32'h20);
		wr(cchf_pkg::REG_MODE, 32'h3);
		waitIrq();
		rd(cchf_pkg::REG_IRQSTAT, 32'h20, "meas stat");
		fork
			cchf_field_inst.pulse(1'b1, 7);
			cchf_field_inst.pulse(1'b0, 3);
		join
		waitIrq();
		rd(cchf_pkg::REG_FREQ, 32'h7, "freq");
		conclude();
	end
endmodule // cchf_counter_tb
bind cchf_counter cchf_properties cchf_properties_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.regAddr(regAddr), .regRd(regRd), .regRdata(regRdata), .cmpOut(cmpOut), .irqOut(irqOut),
	.diagIrq(diagIrq));
